/* File: logic/i2c_irq_ctrl.sv */
// interrupt enables, fifo error flags and interrupt request of the
// two-wire controller, reached over AXI4-Lite
// assumes the bus engine supplies event pulses and fifo levels on clk,
// and that scl and sda arrive straight from the pins
`timescale 1ns/1ps
`include "i2c_irq_map.svh"

module i2c_irq_ctrl (
    input wire logic clk,
    input wire logic rst,
    // axi4-lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // bus pins, asynchronous to clk
    input wire logic scl_in,
    input wire logic sda_in,
    // bus engine and fifo status, on clk
    input wire logic [15:0] evt_pulse,
    input wire logic slave_mode,
    input wire logic ack_slot,
    input wire logic tx_empty,
    input wire logic rx_push,
    input wire logic rx_full,
    input wire logic [3:0] tx_count,
    input wire logic [3:0] tx_thresh,
    input wire logic [3:0] rx_count,
    input wire logic [3:0] rx_thresh,
    // interrupt request
    output logic irq
);

    function automatic i2c_irq_pkg::reg_sel_t decode(input logic [7:0] a);
        case (a)
            `EN0_OFS: decode = i2c_irq_pkg::sel_en0;
            `FL1_OFS: decode = i2c_irq_pkg::sel_fl1;
            `EN1_OFS: decode = i2c_irq_pkg::sel_en1;
            `EVT_OFS: decode = i2c_irq_pkg::sel_evt;
            default: decode = i2c_irq_pkg::sel_none;
        endcase
    endfunction : decode

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        merge = (old & ~m) | (d & m);
    endfunction : merge

    logic [7:0] aw_addr_q;
    logic aw_held;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_held;
    logic [15:0] en0;
    logic [1:0] en1;
    i2c_irq_pkg::fifo_err_t fl1;
    i2c_irq_pkg::event_vec_t evt_status;
    logic tx_th_level;
    logic rx_th_level;
    logic scl_meta;
    logic scl_sync;
    logic scl_prev;
    logic sda_meta;
    logic sda_sync;
    logic scl_rise;
    logic wr_commit;
    logic rd_take;
    logic evt_rd_clear;
    logic underflow_set;
    logic overflow_set;
    logic [1:0] fl1_clear;
    i2c_irq_pkg::reg_sel_t wr_sel;
    i2c_irq_pkg::reg_sel_t rd_sel;
    logic [31:0] wr_val;
    logic [31:0] en0_merged;
    logic [31:0] en1_merged;
    logic next_irq;

    assign wr_commit = aw_held && w_held && !bvalid;
    assign rd_take = arvalid && arready;
    assign wr_sel = decode(aw_addr_q);
    assign rd_sel = decode(araddr);
    assign wr_val = merge(32'h00000000, w_data_q, w_strb_q);
    // byte lanes merge at full width; only the stored bits are kept
    assign en0_merged = merge({16'h0000, en0}, w_data_q, w_strb_q);
    assign en1_merged = merge({30'h00000000, en1}, w_data_q, w_strb_q);
    assign evt_rd_clear = rd_take && (rd_sel == i2c_irq_pkg::sel_evt);

    // write address and data are caught independently, in either order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awready <= 1'b0;
            aw_held <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            aw_held <= 1'b1;
            aw_addr_q <= awaddr;
        end else if (bvalid && bready) begin
            aw_held <= 1'b0;
            awready <= 1'b1;
        end else if (!aw_held && !bvalid) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wready <= 1'b0;
            w_held <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            w_held <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end else if (bvalid && bready) begin
            w_held <= 1'b0;
            wready <= 1'b1;
        end else if (!w_held && !bvalid) begin
            wready <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else if (wr_commit) begin
            bvalid <= 1'b1;
            bresp <= (wr_sel == i2c_irq_pkg::sel_none) ?
                     `RESP_SLVERR : `RESP_OKAY;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end
    end

    // read data is sampled at the address handshake, so a read of the
    // event register clears exactly the sticky bits it returns
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
        end else if (rd_take) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= `RESP_OKAY;
            case (rd_sel)
                i2c_irq_pkg::sel_en0: rdata <= {16'h0000, en0};
                i2c_irq_pkg::sel_fl1: rdata <= {30'h00000000, fl1};
                i2c_irq_pkg::sel_en1: rdata <= {30'h00000000, en1};
                i2c_irq_pkg::sel_evt: rdata <= {16'h0000, evt_status};
                default: begin
                    rdata <= 32'h00000000;
                    rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    // enable registers; upper bits are not stored and read as zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en0 <= `EN0_RST;
            en1 <= `EN1_RST;
        end else if (wr_commit) begin
            if (wr_sel == i2c_irq_pkg::sel_en0) begin
                en0 <= en0_merged[15:0];
            end
            if (wr_sel == i2c_irq_pkg::sel_en1) begin
                en1 <= en1_merged[1:0];
            end
        end
    end

    // pin synchronisers; only the second stage, and the scl copy behind it, is looked at
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
        end
    end

    assign scl_rise = scl_sync && !scl_prev;

    // the master's ack is sampled on the rising scl edge of the ack slot
    assign underflow_set = slave_mode && ack_slot && scl_rise &&
                           !sda_sync && tx_empty;
    assign overflow_set = slave_mode && rx_push && rx_full;
    assign fl1_clear = (wr_commit && wr_sel == i2c_irq_pkg::sel_fl1) ?
                       (wr_val[1:0]) : 2'h0;

    // a set arriving with the clear wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fl1 <= `FL1_RST;
        end else begin
            fl1[`BIT_UNDER] <= underflow_set ||
                (fl1[`BIT_UNDER] && !fl1_clear[`BIT_UNDER]);
            fl1[`BIT_OVER] <= overflow_set ||
                (fl1[`BIT_OVER] && !fl1_clear[`BIT_OVER]);
        end
    end

    // threshold levels are live conditions, not sticky
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_th_level <= 1'b1;
            rx_th_level <= 1'b1;
        end else begin
            tx_th_level <= (tx_count <= tx_thresh);
            rx_th_level <= (rx_count >= rx_thresh);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `EN0_W; gi++) begin : g_evt
            if (gi == `BIT_TXTH) begin : g_tx
                assign evt_status[gi] = tx_th_level;
            end else if (gi == `BIT_RXTH) begin : g_rx
                assign evt_status[gi] = rx_th_level;
            end else begin : g_sticky
                logic bit_q;
                always_ff @(posedge clk or posedge rst) begin
                    if (rst) begin
                        bit_q <= 1'b0;
                    end else begin
                        bit_q <= evt_pulse[gi] || (bit_q && !evt_rd_clear);
                    end
                end
                assign evt_status[gi] = bit_q;
            end
        end
    endgenerate

    // one request line for both enable registers
    assign next_irq = (|(evt_status & en0)) ||
                      (|(fl1 & en1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    chk_irq_all_masked: assert property (
        @(posedge clk) disable iff (rst)
        (en0 == 16'h0000 && en1 == 2'h0) |=> !irq)
        else $error("interrupt raised with all enables clear");

    chk_txlock_gate: assert property (
        @(posedge clk) disable iff (rst)
        (evt_pulse[15] && en0[15]) |=> ##1 irq)
        else $error("enabled tx lock-out event gave no interrupt");

    chk_stop_gate: assert property (
        @(posedge clk) disable iff (rst)
        (evt_status[6] && en0[6]) |=> irq)
        else $error("enabled stop flag gave no interrupt");

    chk_under_gate: assert property (
        @(posedge clk) disable iff (rst)
        (fl1[`BIT_UNDER] && en1[`BIT_UNDER]) |=> irq)
        else $error("enabled underflow flag gave no interrupt");

    chk_under_set: assert property (
        @(posedge clk) disable iff (rst)
        (slave_mode && ack_slot && scl_rise && !sda_sync && tx_empty)
        |=> fl1[`BIT_UNDER])
        else $error("underflow flag not set on acked empty fifo");

    chk_under_quiet: assert property (
        @(posedge clk) disable iff (rst)
        (!fl1[`BIT_UNDER] && !(slave_mode && tx_empty))
        |=> !fl1[`BIT_UNDER])
        else $error("underflow flag set without an empty slave fifo");

    chk_over_set: assert property (
        @(posedge clk) disable iff (rst)
        (slave_mode && rx_push && rx_full) |=> fl1[`BIT_OVER])
        else $error("overflow flag not set on fifo overflow");

    chk_over_w1c: assert property (
        @(posedge clk) disable iff (rst)
        (wr_commit && wr_sel == i2c_irq_pkg::sel_fl1 && w_strb_q[0] &&
         !overflow_set) |=> (fl1[`BIT_OVER] ==
         ($past(fl1[`BIT_OVER]) && !$past(w_data_q[0]))))
        else $error("overflow flag write-one-to-clear misbehaved");

    chk_txth_level: assert property (
        @(posedge clk) disable iff (rst)
        (tx_count <= tx_thresh) |=> evt_status[`BIT_TXTH])
        else $error("tx threshold flag missing at low fill");

    chk_txth_drop: assert property (
        @(posedge clk) disable iff (rst)
        (tx_count > tx_thresh) |=> !evt_status[`BIT_TXTH])
        else $error("tx threshold flag stayed above threshold");

    chk_rxth_level: assert property (
        @(posedge clk) disable iff (rst)
        (rx_count >= rx_thresh) |=> evt_status[`BIT_RXTH])
        else $error("rx threshold flag missing at high fill");

    chk_rxth_drop: assert property (
        @(posedge clk) disable iff (rst)
        (rx_count < rx_thresh) |=> !evt_status[`BIT_RXTH])
        else $error("rx threshold flag stayed below threshold");

    chk_irq_release: assert property (
        @(posedge clk) disable iff (rst)
        (!next_irq [*2]) |-> !irq)
        else $error("interrupt held with no enabled flag");

    chk_en0_write: assert property (
        @(posedge clk) disable iff (rst)
        (wr_commit && wr_sel == i2c_irq_pkg::sel_en0 && w_strb_q == 4'hf)
        |=> en0 == $past(w_data_q[15:0]))
        else $error("enable register did not take the written value");

    chk_bvalid_hold: assert property (@(posedge clk) disable iff (rst)
        (bvalid && !bready) |=> (bvalid && $stable(bresp)))
        else $error("write response dropped before bready");

    chk_rvalid_hold: assert property (@(posedge clk) disable iff (rst)
        (rvalid && !rready) |=> (rvalid && $stable(rdata)))
        else $error("read data dropped before rready");

endmodule : i2c_irq_ctrl

/* File: logic/i2c_irq_map.svh */
// register offsets, field positions and codes of the interrupt block
// assumes byte addressing on an 8-bit AXI4-Lite address
`ifndef I2C_IRQ_MAP_SVH
`define I2C_IRQ_MAP_SVH

`define ADDR_W 8
`define EN0_OFS 8'h0c
`define FL1_OFS 8'h10
`define EN1_OFS 8'h14
`define EVT_OFS 8'h20

`define EN0_W 16
`define EN1_W 2
`define EN0_RST 16'h0000
`define EN1_RST 2'h0
`define FL1_RST 2'h0

`define BIT_TXTH 5
`define BIT_RXTH 4
`define BIT_UNDER 1
`define BIT_OVER 0

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: logic/i2c_irq_pkg.sv */
// types shared by the interrupt block
// assumes the map header is compiled alongside
package i2c_irq_pkg;
    typedef enum {sel_none, sel_en0, sel_fl1, sel_en1, sel_evt} reg_sel_t;
    typedef logic [15:0] event_vec_t;
    typedef logic [1:0] fifo_err_t;
endpackage : i2c_irq_pkg

/* File: test/i2c_interrupt_enable_and_fifo_flags_tb_top.sv */
// bench for the interrupt enable and fifo flag block
// assumes a 25 MHz clock and the map header beside the design
`timescale 1ns/1ps
`include "i2c_irq_map.svh"

module i2c_interrupt_enable_and_fifo_flags_tb_top;
    logic clk = 1'b0, rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    wire scl, sda;
    logic [15:0] evt_pulse = 16'h0;
    logic slave_mode = 1'b0, ack_slot = 1'b0, tx_empty = 1'b0;
    logic rx_push = 1'b0, rx_full = 1'b0;
    logic [3:0] tx_count = 4'h8, tx_thresh = 4'h1;
    logic [3:0] rx_count = 4'h0, rx_thresh = 4'h1;
    int miscompares = 0, check_count = 0;

    always #20 clk = ~clk;

    i2c_peer_model peer (.scl(scl), .sda(sda));

    i2c_irq_ctrl dut (.clk(clk), .rst(rst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .scl_in(scl), .sda_in(sda), .evt_pulse(evt_pulse),
        .slave_mode(slave_mode), .ack_slot(ack_slot), .tx_empty(tx_empty),
        .rx_push(rx_push), .rx_full(rx_full), .tx_count(tx_count),
        .tx_thresh(tx_thresh), .rx_count(rx_count), .rx_thresh(rx_thresh),
        .irq(irq));

    task test_done;
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // both channels offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // this wait ends once bvalid is seen; the watchdog catches a hang
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
        check(rdata, ed);
        check({30'h0, rresp}, {30'h0, er});
    endtask : rd

    task t_reset;
        rd(`EN0_OFS, 32'h0, `RESP_OKAY);
        rd(`EN1_OFS, 32'h0, `RESP_OKAY);
        rd(`FL1_OFS, 32'h0, `RESP_OKAY);
        rd(8'h40, 32'h0, `RESP_SLVERR);
        wr(8'h40, 32'h0, `RESP_SLVERR);
        wr(`EN0_OFS, 32'h0000ffff, `RESP_OKAY);
        rd(`EN0_OFS, 32'h0000ffff, `RESP_OKAY);
        // only the low byte lane is written
        wstrb <= 4'h1;
        wr(`EN0_OFS, 32'h0, `RESP_OKAY);
        rd(`EN0_OFS, 32'h0000ff00, `RESP_OKAY);
        wstrb <= 4'hf;
        wr(`EN0_OFS, 32'h0, `RESP_OKAY);
    endtask : t_reset

    // each sticky event (all but bits 4 and 5) held masked, then unmasked, then cleared by the read
    task t_gate;
        for (int i = 0; i < 16; i++) begin
            if (i == 4 || i == 5) continue;
            @(posedge clk);
            evt_pulse <= 16'h0001 << i;
            @(posedge clk);
            evt_pulse <= 16'h0;
            cyc(4);
            check({31'h0, irq}, 32'h0);
            wr(`EN0_OFS, 32'h1 << i, `RESP_OKAY);
            cyc(3);
            check({31'h0, irq}, 32'h1);
            rd(`EVT_OFS, 32'h1 << i, `RESP_OKAY);
            cyc(3);
            check({31'h0, irq}, 32'h0);
        end
        // lock-out event arriving with its enable already set
        wr(`EN0_OFS, 32'h00008000, `RESP_OKAY);
        @(posedge clk);
        evt_pulse <= 16'h8000;
        @(posedge clk);
        evt_pulse <= 16'h0;
        cyc(2);
        check({31'h0, irq}, 32'h1);
        rd(`EVT_OFS, 32'h00008000, `RESP_OKAY);
        wr(`EN0_OFS, 32'h0, `RESP_OKAY);
    endtask : t_gate

    task t_thresh;
        wr(`EN0_OFS, 32'h1 << `BIT_TXTH, `RESP_OKAY);
        tx_thresh <= 4'h3;
        tx_count <= 4'h3;
        cyc(4);
        check({31'h0, irq}, 32'h1);
        tx_count <= 4'h4;
        cyc(4);
        check({31'h0, irq}, 32'h0);
        wr(`EN0_OFS, 32'h1 << `BIT_RXTH, `RESP_OKAY);
        rx_thresh <= 4'h2;
        rx_count <= 4'h2;
        cyc(4);
        check({31'h0, irq}, 32'h1);
        rx_count <= 4'h1;
        cyc(4);
        check({31'h0, irq}, 32'h0);
        wr(`EN0_OFS, 32'h0, `RESP_OKAY);
    endtask : t_thresh

    task push_rx(input logic full);
        @(posedge clk);
        slave_mode <= 1'b1;
        rx_full <= full;
        rx_push <= 1'b1;
        @(posedge clk);
        rx_push <= 1'b0;
        rx_full <= 1'b0;
        cyc(3);
    endtask : push_rx

    task t_over;
        push_rx(1'b0);
        rd(`FL1_OFS, 32'h0, `RESP_OKAY);
        push_rx(1'b1);
        check({31'h0, irq}, 32'h0);
        rd(`FL1_OFS, 32'h1, `RESP_OKAY);
        wr(`EN1_OFS, 32'h1, `RESP_OKAY);
        cyc(3);
        check({31'h0, irq}, 32'h1);
        wr(`FL1_OFS, 32'h0, `RESP_OKAY);
        rd(`FL1_OFS, 32'h1, `RESP_OKAY);
        wr(`FL1_OFS, 32'h1, `RESP_OKAY);
        rd(`FL1_OFS, 32'h0, `RESP_OKAY);
        check({31'h0, irq}, 32'h0);
    endtask : t_over

    // the gating inputs stay up until the synchronised scl edge lands
    task t_under;
        wr(`EN1_OFS, 32'h2, `RESP_OKAY);
        @(posedge clk);
        slave_mode <= 1'b1;
        tx_empty <= 1'b1;
        ack_slot <= 1'b1;
        peer.ack_bit(1'b0);
        cyc(5);
        rd(`FL1_OFS, 32'h0, `RESP_OKAY);
        peer.ack_bit(1'b1);
        cyc(5);
        rd(`FL1_OFS, 32'h2, `RESP_OKAY);
        check({31'h0, irq}, 32'h1);
        ack_slot <= 1'b0;
        tx_empty <= 1'b0;
        wr(`FL1_OFS, 32'h2, `RESP_OKAY);
        rd(`FL1_OFS, 32'h0, `RESP_OKAY);
        cyc(3);
        check({31'h0, irq}, 32'h0);
    endtask : t_under

    initial begin
        #2_000_000;
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        test_done();
    end

    initial begin
        cyc(12);
        rst <= 1'b0;
        cyc(2);
        t_reset();
        t_gate();
        t_thresh();
        t_over();
        t_under();
        test_done();
    end
endmodule : i2c_interrupt_enable_and_fifo_flags_tb_top

/* File: test/i2c_peer_model.sv */
// far-side model of the two-wire bus: another party clocking an ack bit
// assumes open-drain lines with pull-ups, so idle reads as high
`timescale 1ns/1ps

module i2c_peer_model (
    // bus lines as seen by the block
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // one ack-slot bit at 320 ns; pulled low means the master wants more
    task ack_bit(input logic ack);
        // keep pin changes off the block's sampling edge
        #10;
        scl = 1'b0;
        #80;
        sda = !ack;
        #80;
        scl = 1'b1;
        #80;
        scl = 1'b0;
        #80;
        // released lines return to the pull-up level
        sda = 1'b1;
        scl = 1'b1;
    endtask : ack_bit
endmodule : i2c_peer_model
